// ### link_gpio_defs.svh
// Register indexes, field positions, codes and reset values of the link pin block.
// Included by the package and the design; holds definitions only.
`ifndef LINK_GPIO_DEFS_SVH
`define LINK_GPIO_DEFS_SVH
// Register indexes; byte address is four times the index
`define IDX_PIN0_CFG 8'h1D
`define IDX_PIN12_CFG 8'h1E
`define IDX_PIN3_CFG 8'h1F
`define IDX_LOCAL56_CFG 8'h20
`define IDX_LOCAL78_CFG 8'h21
`define IDX_BC_RATE 8'h23
`define IDX_PORT_SEL 8'h34
`define IDX_FAST_CTL 8'h43
`define IDX_CTRL 8'h50
`define IDX_PIN_STAT0 8'h6E
`define IDX_PIN_STAT1 8'h6F
// Field positions
`define BC_DIV_SEL_BIT 6
`define BC_FAST_BIT 4
`define PSEL_FIRST_BIT 0
`define PSEL_SECOND_BIT 1
`define IRQ_FWD_BIT 0
// Pin configuration codes
`define CFG_FWD_OUT 4'h5
`define CFG_BC_IN 4'h3
`define CFG_OUT_LOW 4'h1
`define CFG_OUT_HIGH 4'h9
// Fast channel mode codes
`define MODE_NORMAL 3'h0
`define MODE_FAST1 3'h1
`define MODE_FAST2 3'h2
`define MODE_FAST4 3'h3
// Samples per frame in each mode
`define SPF_NORMAL 5'h01
`define SPF_FAST4 5'h06
`define SPF_FAST2 5'h0A
`define SPF_FAST1 5'h0F
// Oscillator divide ratios
`define DIV_SLOW 3'h4
`define DIV_MID 3'h2
`define DIV_FAST 3'h1
// Reset values
`define RST_CFG 8'h00
`define RST_PORT_SEL 8'h01
`define RST_ZERO 8'h00
`endif

// ### link_gpio_pkg.sv
// Types shared by the link pin block.
// Assumes link_gpio_defs.svh is on the include path.
`include "link_gpio_defs.svh"
package link_gpio_pkg;
   // Back channel sequencer, Gray coded along idle, sync, run
   typedef enum logic [1:0]
   {
      BC_IDLE = 2'b00,
      BC_SYNC = 2'b01,
      BC_RUN = 2'b11
   } bc_state_t;
   typedef logic [3:0] pin_cfg_t;
endpackage

// ### link_gpio_backchannel_cfg.sv
// Link-side pin configuration, back channel pacing and interrupt forwarding.
// Assumes an APB master on clk, synchronous inputs and a one-cycle osc_tick
// from the internal oscillator; pin wires are resolved outside from the enables.
//
// Operation
// - Low power-down input idles the block
// - Forward active-low downstream interrupt when enabled
// - Pull interrupt pin low during power-down
// - Link pins are forward outputs or back inputs
// - Port select bits route shared pin fields
// - Secondary-lane pins only in two-lane mode
// - Code 5 forward output, 3 back input
// - Pin values readable, local output possible
// - Divider bit selects divide by four or two
// - Fast bit or strap forces divide by one
// - Mode field zero gives normal four-pin sampling
// - Fast modes drop normal back channel signaling
// - Accept auto-loaded 18-bit mode from serializer
// - Four local pins, register access only
// - Local pin mode overrides shared audio input
// - Local codes 1 low, 9 high, 3 input
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "link_gpio_defs.svh"
module link_gpio_backchannel_cfg #(
   parameter int APB_AW = 10,
   parameter int FRAME_BITS = 30
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic power_down_n,
   input wire logic strap_select_one,
   input wire logic two_lane_mode,
   input wire logic eighteen_bit_load,
   input wire logic osc_tick,
   input wire logic downstream_irq_in_n,
   output logic downstream_irq_out,
   output logic downstream_irq_oe_n,
   input wire logic [3:0] fwd_pin_data,
   input wire logic [3:0] fwd_sec_pin_data,
   input wire logic [3:0] link_pin_in,
   output logic [3:0] link_pin_out,
   output logic [3:0] link_pin_oe_n,
   input wire logic [3:0] sec_pin_in,
   output logic [3:0] sec_pin_out,
   output logic [3:0] sec_pin_oe_n,
   input wire logic [3:0] local_pin_in,
   output logic [3:0] local_pin_out,
   output logic [3:0] local_pin_oe_n,
   output logic [3:0] audio_in_disable,
   output logic [7:0] bc_pin_sample,
   output logic bc_sample_valid,
   output logic bc_bit_tick,
   output logic bc_frame_start,
   output logic bc_normal_signaling,
   output logic bc_irq_n,
   output logic eighteen_bit_mode
);
   // Elaboration checks: the fastest mode needs a whole bit per sample
   if (APB_AW < 10) begin : g_aw_chk
      $error("APB_AW too small for the register map");
   end
   if (FRAME_BITS < 15 || FRAME_BITS > 255) begin : g_fb_chk
      $error("FRAME_BITS out of range");
   end

   // Decode a 4-bit pin code: enable and value for an output pin
   function automatic logic [1:0] pin_drive(input link_gpio_pkg::pin_cfg_t c, input logic fwd);
      case (c)
         `CFG_FWD_OUT: pin_drive = {1'b1, fwd};
         `CFG_OUT_LOW: pin_drive = 2'b10;
         `CFG_OUT_HIGH: pin_drive = 2'b11;
         default: pin_drive = 2'b00;
      endcase
   endfunction

   // Register state
   link_gpio_pkg::pin_cfg_t cfg_r [2][4];
   logic [7:0] local_cfg_r [2];
   logic [7:0] rate_r;
   logic [1:0] port_sel_r;
   logic [2:0] mode_r;
   logic irq_fwd_en_r;
   logic strap_fast_r;
   logic eighteen_r;
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;

   // Bus decode
   logic [7:0] idx;
   logic addr_ok;
   logic acc_start;
   logic wr_now;
   logic sel_second;
   assign idx = paddr[9:2];
   assign acc_start = psel && penable && !pready_r;
   assign wr_now = psel && penable && pready_r && pwrite && addr_ok;
   assign sel_second = port_sel_r[`PSEL_SECOND_BIT];
   // Shift instead of a part-select so the default width needs no empty range
   assign addr_ok = (paddr[1:0] == 2'h0) && ((paddr >> 10) == '0) &&
      (idx == `IDX_PIN0_CFG || idx == `IDX_PIN12_CFG || idx == `IDX_PIN3_CFG ||
       idx == `IDX_LOCAL56_CFG || idx == `IDX_LOCAL78_CFG || idx == `IDX_BC_RATE ||
       idx == `IDX_PORT_SEL || idx == `IDX_FAST_CTL || idx == `IDX_CTRL ||
       idx == `IDX_PIN_STAT0 || idx == `IDX_PIN_STAT1);

   // Read mux; shared pin fields show the second lane when its bit is set
   logic [7:0] rd_byte;
   logic [3:0] lpin_val;
   logic [3:0] spin_val;
   logic [3:0] shown_pins;
   assign lpin_val = link_pin_in;
   assign spin_val = sec_pin_in;
   assign shown_pins = sel_second ? spin_val : lpin_val;
   always_comb
   begin
      case (idx)
         `IDX_PIN0_CFG: rd_byte = {4'h0, cfg_r[sel_second][0]};
         `IDX_PIN12_CFG: rd_byte = {cfg_r[sel_second][2], cfg_r[sel_second][1]};
         `IDX_PIN3_CFG: rd_byte = {4'h0, cfg_r[sel_second][3]};
         `IDX_LOCAL56_CFG: rd_byte = local_cfg_r[0];
         `IDX_LOCAL78_CFG: rd_byte = local_cfg_r[1];
         `IDX_BC_RATE: rd_byte = rate_r;
         `IDX_PORT_SEL: rd_byte = {6'h00, port_sel_r};
         `IDX_FAST_CTL: rd_byte = {5'h00, mode_r};
         `IDX_CTRL: rd_byte = {4'h0, strap_fast_r, eighteen_r, 1'b0, irq_fwd_en_r};
         `IDX_PIN_STAT0: rd_byte = {local_pin_in[2:0], 1'b0, shown_pins};
         `IDX_PIN_STAT1: rd_byte = {7'h00, local_pin_in[3]};
         default: rd_byte = `RST_ZERO;
      endcase
   end

   // APB answer: pready one cycle into the access phase, write lands with it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= acc_start;
         prdata_r <= (acc_start && !pwrite && addr_ok) ? {24'h000000, rd_byte} : 32'h0000_0000;
         pslverr_r <= acc_start && !addr_ok;
      end
   end

   // Configuration registers; writes go to every selected port
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int p = 0; p < 2; p++)
         begin
            for (int i = 0; i < 4; i++)
               cfg_r[p][i] <= 4'h0;
            local_cfg_r[p] <= `RST_CFG;
         end
         rate_r <= `RST_ZERO;
         port_sel_r <= 2'(`RST_PORT_SEL);
         mode_r <= `MODE_NORMAL;
         irq_fwd_en_r <= 1'b0;
      end
      else if (wr_now)
      begin
         for (int p = 0; p < 2; p++)
         begin
            if (port_sel_r[p])
            begin
               if (idx == `IDX_PIN0_CFG) cfg_r[p][0] <= pwdata[3:0];
               if (idx == `IDX_PIN12_CFG) cfg_r[p][1] <= pwdata[3:0];
               if (idx == `IDX_PIN12_CFG) cfg_r[p][2] <= pwdata[7:4];
               if (idx == `IDX_PIN3_CFG) cfg_r[p][3] <= pwdata[3:0];
            end
         end
         if (idx == `IDX_LOCAL56_CFG) local_cfg_r[0] <= pwdata[7:0];
         if (idx == `IDX_LOCAL78_CFG) local_cfg_r[1] <= pwdata[7:0];
         if (idx == `IDX_BC_RATE) rate_r <= pwdata[7:0];
         if (idx == `IDX_PORT_SEL) port_sel_r <= pwdata[1:0];
         if (idx == `IDX_FAST_CTL) mode_r <= pwdata[2:0];
         if (idx == `IDX_CTRL) irq_fwd_en_r <= pwdata[`IRQ_FWD_BIT];
      end
   end

   // Strap caught on the first edge after reset release, not under reset
   logic strap_taken_r;
   always_ff @(posedge clk)
   begin
      if (rst)
         strap_taken_r <= 1'b0;
      else
         strap_taken_r <= 1'b1;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         strap_fast_r <= 1'b0;
      else if (!strap_taken_r)
         strap_fast_r <= strap_select_one;
   end

   // 18-bit mode is loaded by the serializer, sticky until reset
   always_ff @(posedge clk)
   begin
      if (rst)
         eighteen_r <= 1'b0;
      else if (eighteen_bit_load)
         eighteen_r <= 1'b1;
   end

   // Back channel rate: the fast bit or strap wins over the divider bit
   logic [2:0] div_ratio;
   logic fast_bc;
   assign fast_bc = rate_r[`BC_FAST_BIT] || strap_fast_r;
   assign div_ratio = fast_bc ? `DIV_FAST :
      (rate_r[`BC_DIV_SEL_BIT] ? `DIV_MID : `DIV_SLOW);

   // Samples per frame and pins carried per mode
   logic [4:0] spf;
   logic [3:0] pin_mask;
   logic [7:0] sample_gap;
   always_comb
   begin
      case (mode_r)
         `MODE_FAST4: spf = `SPF_FAST4;
         `MODE_FAST2: spf = `SPF_FAST2;
         `MODE_FAST1: spf = `SPF_FAST1;
         default: spf = `SPF_NORMAL;
      endcase
      case (mode_r)
         `MODE_FAST2: pin_mask = 4'h3;
         `MODE_FAST1: pin_mask = 4'h1;
         default: pin_mask = 4'hF;
      endcase
   end
   assign sample_gap = 8'(FRAME_BITS / int'(spf));

   // Back channel sequencer: divider, bit count and sample points
   link_gpio_pkg::bc_state_t state_r;
   link_gpio_pkg::bc_state_t state_nxt;
   logic [2:0] div_cnt_r;
   logic [7:0] bit_cnt_r;
   logic [7:0] gap_cnt_r;
   logic bit_tick;
   logic frame_end;
   logic sample_now;
   // Gated by power-down so no tick escapes in the cycle the sequencer is parked
   assign bit_tick = osc_tick && power_down_n && (div_cnt_r >= div_ratio - 3'h1) &&
      state_r != link_gpio_pkg::BC_IDLE;
   assign frame_end = bit_tick && (bit_cnt_r == 8'(FRAME_BITS - 1));
   assign sample_now = bit_tick && state_r == link_gpio_pkg::BC_RUN && (gap_cnt_r == sample_gap - 8'h01);
   always_comb
   begin
      case (state_r)
         link_gpio_pkg::BC_IDLE: state_nxt = link_gpio_pkg::BC_SYNC;
         link_gpio_pkg::BC_SYNC: state_nxt = bit_tick ? link_gpio_pkg::BC_RUN : link_gpio_pkg::BC_SYNC;
         link_gpio_pkg::BC_RUN: state_nxt = link_gpio_pkg::BC_RUN;
         default: state_nxt = link_gpio_pkg::BC_IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (rst || !power_down_n)
      begin
         state_r <= link_gpio_pkg::BC_IDLE;
         div_cnt_r <= 3'h0;
         bit_cnt_r <= 8'h00;
         gap_cnt_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         if (osc_tick)
            div_cnt_r <= (div_cnt_r >= div_ratio - 3'h1) ? 3'h0 : div_cnt_r + 3'h1;
         if (bit_tick)
         begin
            bit_cnt_r <= frame_end ? 8'h00 : bit_cnt_r + 8'h01;
            gap_cnt_r <= (frame_end || gap_cnt_r == sample_gap - 8'h01) ? 8'h00 : gap_cnt_r + 8'h01;
         end
      end
   end

   // Input pins feed the back channel only when coded as inputs
   logic [3:0] bc_in_pri;
   logic [3:0] bc_in_sec;
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         bc_in_pri[i] = (cfg_r[0][i] == `CFG_BC_IN) && link_pin_in[i];
         bc_in_sec[i] = (cfg_r[1][i] == `CFG_BC_IN) && two_lane_mode && sec_pin_in[i];
      end
   end

   // Pin drive decode for link, secondary-lane and local pins
   logic [1:0] drv_pri [4];
   logic [1:0] drv_sec [4];
   logic [1:0] drv_loc [4];
   logic [3:0] loc_is_gpio;
   link_gpio_pkg::pin_cfg_t loc_code [4];
   assign loc_code[0] = local_cfg_r[0][3:0];
   assign loc_code[1] = local_cfg_r[0][7:4];
   assign loc_code[2] = local_cfg_r[1][3:0];
   assign loc_code[3] = local_cfg_r[1][7:4];
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         drv_pri[i] = pin_drive(cfg_r[0][i], fwd_pin_data[i]);
         drv_sec[i] = two_lane_mode ? pin_drive(cfg_r[1][i], fwd_sec_pin_data[i]) : 2'b00;
         drv_loc[i] = (loc_code[i] == `CFG_FWD_OUT) ? 2'b00 : pin_drive(loc_code[i], 1'b0);
         loc_is_gpio[i] = drv_loc[i][1] || loc_code[i] == `CFG_BC_IN;
      end
   end

   // Registered outputs; power-down floats every pin but the interrupt
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         link_pin_out <= 4'h0;
         link_pin_oe_n <= 4'hF;
         sec_pin_out <= 4'h0;
         sec_pin_oe_n <= 4'hF;
         local_pin_out <= 4'h0;
         local_pin_oe_n <= 4'hF;
         audio_in_disable <= 4'h0;
         downstream_irq_out <= 1'b0;
         downstream_irq_oe_n <= 1'b1;
         bc_irq_n <= 1'b1;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            link_pin_out[i] <= drv_pri[i][0];
            link_pin_oe_n[i] <= !(drv_pri[i][1] && power_down_n);
            sec_pin_out[i] <= drv_sec[i][0];
            sec_pin_oe_n[i] <= !(drv_sec[i][1] && power_down_n);
            local_pin_out[i] <= drv_loc[i][0];
            local_pin_oe_n[i] <= !(drv_loc[i][1] && power_down_n);
         end
         audio_in_disable <= loc_is_gpio;
         downstream_irq_out <= 1'b0;
         downstream_irq_oe_n <= power_down_n;
         // Level forward; the serializer latches and clears its own copy
         bc_irq_n <= !(irq_fwd_en_r && power_down_n && !downstream_irq_in_n);
      end
   end

   // Back channel outputs; fast modes carry pins instead of status traffic
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bc_pin_sample <= 8'h00;
         bc_sample_valid <= 1'b0;
         bc_bit_tick <= 1'b0;
         bc_frame_start <= 1'b0;
         bc_normal_signaling <= 1'b1;
         eighteen_bit_mode <= 1'b0;
      end
      else
      begin
         if (sample_now)
            bc_pin_sample <= {bc_in_sec & pin_mask, bc_in_pri & pin_mask};
         bc_sample_valid <= sample_now;
         bc_bit_tick <= bit_tick;
         bc_frame_start <= frame_end;
         bc_normal_signaling <= (mode_r == `MODE_NORMAL);
         eighteen_bit_mode <= eighteen_r;
      end
   end

   assign pready = pready_r;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
endmodule
`default_nettype wire

// ### serializer_model.sv
// Model of the paired serializer: holds its interrupt output low once a
// forwarded interrupt arrives. Assumes bc_irq_n is a level on clk.
`timescale 1ns/1ps
`default_nettype none
module serializer_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic bc_irq_n,
   input wire logic status_read,
   output logic serializer_irq_out_n
);
   // Sticky: the downstream source may let go long before the host reads
   always_ff @(posedge clk)
   begin
      if (rst || status_read)
         serializer_irq_out_n <= 1'b1;
      else if (!bc_irq_n)
         serializer_irq_out_n <= 1'b0;
   end
endmodule
`default_nettype wire

// ### link_gpio_checker.sv
// Port-level assertions for the link pin block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module link_gpio_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic power_down_n,
   input wire logic two_lane_mode,
   input wire logic downstream_irq_in_n,
   input wire logic downstream_irq_out,
   input wire logic downstream_irq_oe_n,
   input wire logic [3:0] link_pin_oe_n,
   input wire logic [3:0] sec_pin_oe_n,
   input wire logic [3:0] local_pin_oe_n,
   input wire logic bc_bit_tick,
   input wire logic bc_sample_valid,
   input wire logic bc_normal_signaling,
   input wire logic bc_irq_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Bus answers come exactly one cycle into the access phase
   a_ready_after_access: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && penable))
      else $error("pready outside access");
   a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error with data");
   a_pd_irq_pull: assert property (!power_down_n |=> !downstream_irq_oe_n && !downstream_irq_out)
      else $error("irq pin not pulled");
   a_pd_pins_hiz: assert property (!power_down_n |=> &{link_pin_oe_n, sec_pin_oe_n, local_pin_oe_n})
      else $error("pin driven in power down");
   a_pd_bc_idle: assert property (!power_down_n |=> !bc_bit_tick && !bc_sample_valid)
      else $error("back channel active in power down");
   a_irq_cause: assert property (!bc_irq_n |-> $past(power_down_n && !downstream_irq_in_n))
      else $error("forwarded irq without cause");
   a_sec_single: assert property (!two_lane_mode |=> &sec_pin_oe_n)
      else $error("second lane driven in one-lane mode");
   c_refused: cover property (pslverr);
   c_irq_fwd: cover property (!bc_irq_n);
   c_fast_sample: cover property (bc_sample_valid && !bc_normal_signaling);
endmodule
bind link_gpio_backchannel_cfg link_gpio_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .power_down_n(power_down_n),
   .two_lane_mode(two_lane_mode), .downstream_irq_in_n(downstream_irq_in_n),
   .downstream_irq_out(downstream_irq_out), .downstream_irq_oe_n(downstream_irq_oe_n),
   .link_pin_oe_n(link_pin_oe_n), .sec_pin_oe_n(sec_pin_oe_n), .local_pin_oe_n(local_pin_oe_n),
   .bc_bit_tick(bc_bit_tick), .bc_sample_valid(bc_sample_valid),
   .bc_normal_signaling(bc_normal_signaling), .bc_irq_n(bc_irq_n));
`default_nettype wire

// ### tb.sv
// Self-checking bench: registers over APB, pin codes, back channel pacing,
// interrupt forwarding. Assumes the design, its header and the model.
`timescale 1ns/1ps
`default_nettype none
`include "link_gpio_defs.svh"
module tb;
   localparam int FRAME = 30;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic power_down_n = 1'b1;
   logic two_lane = 1'b0;
   logic load18 = 1'b0;
   logic osc_tick = 1'b1;
   logic irq_in_n = 1'b1;
   logic isr_rd = 1'b0;
   logic strap = 1'b0;
   logic [3:0] fwd = 4'h0, fwd2 = 4'h0, lin = 4'h0, sin = 4'h0, locin = 4'h0, c;
   wire logic pready, pslverr, irq_out, irq_oe_n, valid, bit_tick, fstart, normal, bc_irq_n, m18, ser_n;
   wire logic [31:0] prdata;
   wire logic [3:0] lout, loe, sout, soe, pout, poe, audis;
   wire logic [7:0] sample;
   logic [31:0] rdq;
   logic rde;
   int mismatches = 0;
   int cmp_count = 0;
   int g;
   logic [3:0] codes [6] = '{`CFG_FWD_OUT, `CFG_BC_IN, `CFG_OUT_LOW, `CFG_OUT_HIGH, 4'h0, 4'hC};
   logic [7:0] ridx [7] = '{`IDX_PORT_SEL, `IDX_PIN0_CFG, `IDX_PIN12_CFG, `IDX_PIN3_CFG, `IDX_BC_RATE,
      `IDX_FAST_CTL, `IDX_CTRL};
   logic [7:0] rates [4] = '{8'h00, 8'h40, 8'h10, 8'h50};
   logic [2:0] divs [4] = '{`DIV_SLOW, `DIV_MID, `DIV_FAST, `DIV_FAST};
   logic [4:0] spf [4] = '{`SPF_NORMAL, `SPF_FAST1, `SPF_FAST2, `SPF_FAST4};
   logic [3:0] masks [4] = '{4'hF, 4'h1, 4'h3, 4'hF};

   link_gpio_backchannel_cfg #(.APB_AW(10), .FRAME_BITS(FRAME)) u_dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .power_down_n(power_down_n), .strap_select_one(strap), .two_lane_mode(two_lane),
      .eighteen_bit_load(load18), .osc_tick(osc_tick), .downstream_irq_in_n(irq_in_n),
      .downstream_irq_out(irq_out), .downstream_irq_oe_n(irq_oe_n), .fwd_pin_data(fwd),
      .fwd_sec_pin_data(fwd2), .link_pin_in(lin), .link_pin_out(lout), .link_pin_oe_n(loe),
      .sec_pin_in(sin), .sec_pin_out(sout), .sec_pin_oe_n(soe), .local_pin_in(locin), .local_pin_out(pout),
      .local_pin_oe_n(poe), .audio_in_disable(audis), .bc_pin_sample(sample), .bc_sample_valid(valid),
      .bc_bit_tick(bit_tick), .bc_frame_start(fstart), .bc_normal_signaling(normal), .bc_irq_n(bc_irq_n),
      .eighteen_bit_mode(m18));
   serializer_model u_ser (.clk(clk), .rst(rst), .bc_irq_n(bc_irq_n), .status_read(isr_rd),
      .serializer_irq_out_n(ser_n));

   // Free-running 200 MHz clock
   always #2.5 clk = ~clk;

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, s);
         mismatches++;
      end
   endtask
   task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] s);
      chk(nm, {28'h0, e}, {28'h0, s});
   endtask
   // One APB transfer; waits for pready, then lets an edge pass before return
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         mismatches++;
         give_verdict();
      end
      rdq = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Cycles between the last two of three pulses: 0 bit tick, 1 sample valid, 2 frame start
   task automatic gap(input logic [1:0] s, output int gp);
      int n;
      for (int k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end while ((((s == 2'd1) ? valid : (s == 2'd2) ? fstart : bit_tick) !== 1'b1) && n < 200);
         if (n >= 200)
         begin
            mismatches++;
            give_verdict();
         end
         gp = n;
      end
   endtask
   task automatic cfg_link(input logic [3:0] k);
      apb(1'b1, {`IDX_PIN0_CFG, 2'b00}, {28'h0, k});
      apb(1'b1, {`IDX_PIN12_CFG, 2'b00}, {24'h0, k, k});
      apb(1'b1, {`IDX_PIN3_CFG, 2'b00}, {28'h0, k});
   endtask
   // Expected enables: low where the code drives the pin
   function automatic logic [3:0] drv(input logic [3:0] k, input bit loc);
      return (k == `CFG_OUT_LOW || k == `CFG_OUT_HIGH || (!loc && k == `CFG_FWD_OUT)) ? 4'h0 : 4'hF;
   endfunction
   function automatic logic [3:0] lvl(input logic [3:0] k, input logic [3:0] f);
      return (k == `CFG_OUT_HIGH) ? 4'hF : (k == `CFG_FWD_OUT) ? f : 4'h0;
   endfunction

   initial
   begin
      void'($urandom(42));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, {ridx[i], 2'b00}, 32'h0);
         chk("reset_value", {24'h0, (i == 0) ? `RST_PORT_SEL : `RST_CFG}, rdq);
      end
      apb(1'b1, 10'h3FC, 32'hFF);
      chk("unmapped_err", 32'h1, {31'h0, rde});
      apb(1'b0, {`IDX_PORT_SEL, 2'b01}, 32'h0);
      chk("misaligned_data", 32'h0, rdq);
      fwd <= 4'($urandom);
      fwd2 <= 4'($urandom);
      lin <= 4'($urandom);
      sin <= 4'($urandom);
      locin <= 4'($urandom);
      codes[5] = 4'($urandom_range(10, 15));
      // Codes 5, 3, 1, 9, 0 and one of 10 to 15 on all link and local pins; codes 0 and 10 to 15 must stay hi-z
      for (int i = 0; i < 6; i++)
      begin
         c = codes[i];
         cfg_link(c);
         apb(1'b1, {`IDX_LOCAL56_CFG, 2'b00}, {24'h0, c, c});
         apb(1'b1, {`IDX_LOCAL78_CFG, 2'b00}, {24'h0, c, c});
         apb(1'b0, {`IDX_PIN_STAT0, 2'b00}, 32'h0);
         chk4("link_oe_n", drv(c, 1'b0), loe);
         chk4("link_out", lvl(c, fwd) & ~drv(c, 1'b0), lout & ~loe);
         chk4("local_oe_n", drv(c, 1'b1), poe);
         chk4("local_out", lvl(c, 4'h0) & ~drv(c, 1'b1), pout & ~poe);
         chk4("audio_off", (c == 4'h1 || c == 4'h9 || c == 4'h3) ? 4'hF : 4'h0, audis);
         if (c == `CFG_BC_IN)
            chk("pin_status", {24'h0, locin[2:0], 1'b0, lin}, rdq & 32'hEF);
      end
      two_lane <= 1'b1;
      apb(1'b1, {`IDX_PORT_SEL, 2'b00}, 32'h2);
      cfg_link(`CFG_FWD_OUT);
      apb(1'b0, {`IDX_PORT_SEL, 2'b00}, 32'h0);
      chk("port_sel", 32'h2, rdq);
      chk4("sec_oe_n", 4'h0, soe);
      chk4("sec_out", fwd2, sout);
      chk4("link_kept", 4'hF, loe);
      two_lane <= 1'b0;
      repeat (2) @(posedge clk);
      chk4("sec_single", 4'hF, soe);
      apb(1'b1, {`IDX_PORT_SEL, 2'b00}, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, {`IDX_BC_RATE, 2'b00}, {24'h0, rates[i]});
         gap(1'b0, g);
         chk("bit_gap", {29'h0, divs[i]}, g);
      end
      // Divide by one now, so bits and cycles coincide; primary pins feed samples
      cfg_link(`CFG_BC_IN);
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, {`IDX_FAST_CTL, 2'b00}, 32'(m));
         gap(1'b1, g);
         chk("sample_gap", 32'(FRAME / spf[m]), g);
         chk4("normal_sig", {3'h0, m == 0}, {3'h0, normal});
         chk("bc_sample", {28'h0, lin & masks[m]}, {24'h0, sample});
      end
      gap(2'd2, g);
      chk("frame_gap", FRAME, g);
      apb(1'b1, {`IDX_CTRL, 2'b00}, 32'h1);
      irq_in_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk4("bc_irq_n", 4'h0, {3'h0, bc_irq_n});
      chk4("ser_irq_n", 4'h0, {3'h0, ser_n});
      irq_in_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk4("ser_irq_held", 4'h0, {3'h0, ser_n});
      isr_rd <= 1'b1;
      @(posedge clk);
      isr_rd <= 1'b0;
      repeat (2) @(posedge clk);
      chk4("ser_irq_clr", 4'h1, {3'h0, ser_n});
      power_down_n <= 1'b0;
      irq_in_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk4("irq_oe_n", 4'h0, {3'h0, irq_oe_n});
      chk4("irq_out_low", 4'h0, {3'h0, irq_out});
      chk4("pd_bc_irq_n", 4'h1, {3'h0, bc_irq_n});
      power_down_n <= 1'b1;
      irq_in_n <= 1'b1;
      load18 <= 1'b1;
      @(posedge clk);
      load18 <= 1'b0;
      apb(1'b0, {`IDX_CTRL, 2'b00}, 32'h0);
      chk("mode18", 32'h4, rdq & 32'h4);
      chk4("mode18_out", 4'h1, {3'h0, m18});
      // Second reset with the strap set: fast back channel without the register bit
      strap <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, {`IDX_CTRL, 2'b00}, 32'h0);
      chk("strap_seen", 32'h8, rdq & 32'h8);
      gap(2'd0, g);
      chk("strap_gap", {29'h0, `DIV_FAST}, g);
      give_verdict();
   end
endmodule
`default_nettype wire
